//--- hdl/flsp_consts.svh
// Opcodes, field positions and reset values of the flash protection block.
// Macros only; included by the design files by bare name.
`ifndef FLSP_CONSTS_SVH
`define FLSP_CONSTS_SVH

`define FLSP_OP_WR_CFG    8'h61
`define FLSP_OP_RD_CFG    8'h65
`define FLSP_OP_WR_PROT   8'h2C
`define FLSP_OP_RD_PROT   8'h2D
`define FLSP_OP_WR_PW     8'h28
`define FLSP_OP_UNLOCK    8'h29
`define FLSP_OP_WR_FRZ    8'hA6
`define FLSP_OP_RD_FRZ    8'hA7
`define FLSP_OP_WR_NVL    8'hE3
`define FLSP_OP_ERASE_NVL 8'hE4
`define FLSP_OP_WR_VLK    8'hE5

`define FLSP_CFG_RST      8'hFF
`define FLSP_CFG_QUAD     7
`define FLSP_CFG_DUAL     6
`define FLSP_CFG_DTR      5
`define FLSP_CFG_HOLD     4
`define FLSP_CFG_RSV      3

`define FLSP_PROT_RST     16'hFFFF
`define FLSP_PROT_RSV     16'hFFF9
`define FLSP_PROT_PW      2
`define FLSP_PROT_SP      1

`define FLSP_FRZ_RST      1'b1
`define FLSP_SUBS_W       4

`endif

//--- hdl/flsp_pkg.sv
// Types shared by the flash protection core and its serial front end.
// No assumptions beyond a SystemVerilog-2012 tool.
package flsp_pkg;

    typedef enum logic [1:0] {
        FLSP_PH_OP   = 2'h0,
        FLSP_PH_DATA = 2'h1,
        FLSP_PH_OUT  = 2'h3,
        FLSP_PH_IDLE = 2'h2
    } flsp_phase_e;

    typedef enum logic [1:0] {
        FLSP_LANE1 = 2'h0,
        FLSP_LANE2 = 2'h1,
        FLSP_LANE4 = 2'h2
    } flsp_lane_e;

endpackage : flsp_pkg

//--- hdl/flsp_link.sv
// Serial front end of the flash protection block, clocked by the host's sck.
// Assumes cs_n high between frames; config and read values are static in a frame.
`timescale 1ns/1ps
`include "flsp_consts.svh"

module flsp_link
    import flsp_pkg::*;
(
    // Link clock, frame and core reset
    input  wire logic        sck_i,
    input  wire logic        cs_n_i,
    input  wire logic        rst_n_i,
    // Data lines
    input  wire logic [3:0]  dq_i,
    output logic      [3:0]  dq_o,
    output logic      [3:0]  dq_oe_o,
    // Values from the core
    input  wire logic [7:0]  cfg_i,
    input  wire logic [31:0] rdval_i,
    // Command hand-off
    output logic             req_tgl_o,
    output logic      [7:0]  req_op_o,
    output logic      [63:0] req_data_o
);

    function automatic logic [3:0] flsp_len(input logic [7:0] op);
        case (op)
            `FLSP_OP_WR_CFG:  return 4'h1;
            `FLSP_OP_WR_PROT: return 4'h2;
            `FLSP_OP_WR_PW:   return 4'h8;
            `FLSP_OP_UNLOCK:  return 4'h8;
            `FLSP_OP_WR_NVL:  return 4'h2;
            `FLSP_OP_WR_VLK:  return 4'h3;
            default:          return 4'h0;
        endcase
    endfunction : flsp_len

    function automatic logic [15:0] flsp_rd(input logic [7:0] op,
                                           input logic [31:0] v);
        case (op)
            `FLSP_OP_RD_CFG:  return {v[31:24], 8'h00};
            `FLSP_OP_RD_PROT: return v[23:8];
            `FLSP_OP_RD_FRZ:  return {v[7:0], 8'h00};
            default:          return 16'h0000;
        endcase
    endfunction : flsp_rd

    logic        arst_n;
    flsp_phase_e ph;
    flsp_lane_e  lane;
    logic [7:0]  sr;
    logic [7:0]  next_byte;
    logic [2:0]  bitcnt;
    logic [3:0]  step;
    logic [3:0]  bytecnt;
    logic [3:0]  need;
    logic [15:0] osr;
    logic        hold;
    logic        byte_done;

    // A frame's own select ends it, so a stopped sck leaves nothing half done
    assign arst_n = rst_n_i & ~cs_n_i;

    assign lane = !cfg_i[`FLSP_CFG_QUAD] ? FLSP_LANE4 :
                  !cfg_i[`FLSP_CFG_DUAL] ? FLSP_LANE2 : FLSP_LANE1;
    assign step = (lane == FLSP_LANE4) ? 4'h4 : (lane == FLSP_LANE2) ? 4'h2 : 4'h1;
    assign next_byte = (lane == FLSP_LANE4) ? {sr[3:0], dq_i} :
                       (lane == FLSP_LANE2) ? {sr[5:0], dq_i[1:0]} : {sr[6:0], dq_i[0]};
    assign byte_done = (({1'b0, bitcnt} + step) == 4'h8);
    // Line three is the hold input unless quad needs it for data
    assign hold = cfg_i[`FLSP_CFG_HOLD] && (lane != FLSP_LANE4) && !dq_i[3];

    always_ff @(posedge sck_i or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ph      <= FLSP_PH_OP;
            sr      <= 8'h00;
            bitcnt  <= 3'h0;
            bytecnt <= 4'h0;
            need    <= 4'h0;
            osr     <= 16'h0000;
        end
        else if (!hold)
        begin
            sr     <= next_byte;
            bitcnt <= 3'({1'b0, bitcnt} + step);
            unique case (ph)
                FLSP_PH_OP:
                    if (byte_done)
                    begin
                        need    <= flsp_len(next_byte);
                        bytecnt <= 4'h0;
                        osr     <= flsp_rd(next_byte, rdval_i);
                        if (flsp_len(next_byte) != 4'h0)
                            ph <= FLSP_PH_DATA;
                        else if (flsp_rd(next_byte, 32'hFFFF_FFFF) != 16'h0000)
                            ph <= FLSP_PH_OUT;
                        else
                            ph <= FLSP_PH_IDLE;
                    end
                FLSP_PH_DATA:
                    if (byte_done)
                    begin
                        bytecnt <= bytecnt + 4'h1;
                        if (bytecnt + 4'h1 == need)
                            ph <= FLSP_PH_IDLE;
                    end
                FLSP_PH_OUT:
                    osr <= osr << step;
                FLSP_PH_IDLE:
                    ph <= FLSP_PH_IDLE;
            endcase
        end
    end

    // Request fields survive the frame end; only the core reset clears them
    always_ff @(posedge sck_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            req_tgl_o  <= 1'b0;
            req_op_o   <= 8'h00;
            req_data_o <= 64'h0;
        end
        else if (!cs_n_i && !hold && byte_done)
        begin
            if (ph == FLSP_PH_OP)
            begin
                req_op_o <= next_byte;
                if (flsp_len(next_byte) == 4'h0)
                    req_tgl_o <= ~req_tgl_o;
            end
            if (ph == FLSP_PH_DATA)
            begin
                req_data_o <= {req_data_o[55:0], next_byte};
                if (bytecnt + 4'h1 == need)
                    req_tgl_o <= ~req_tgl_o;
            end
        end
    end

    assign dq_oe_o = (ph != FLSP_PH_OUT) ? 4'h0 :
                     (lane == FLSP_LANE4) ? 4'hF : (lane == FLSP_LANE2) ? 4'h3 : 4'h2;
    assign dq_o = (lane == FLSP_LANE4) ? osr[15:12] :
                  (lane == FLSP_LANE2) ? {2'b00, osr[15:14]} : {2'b00, osr[15], 1'b0};

endmodule : flsp_link

//--- hdl/flsp_core.sv
// Configuration, sector protection and lock-bit freeze of a serial flash.
// Assumes a serial host on sck/cs_n/dq and a nonvolatile image on nv_*.
`timescale 1ns/1ps
`include "flsp_consts.svh"

module flsp_core
    import flsp_pkg::*;
#(
    parameter int SECT_W = 10,
    parameter int SUBS   = 16
)
(
    // Core clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   rstn_i,
    // Serial link
    input  wire logic                   sck_i,
    input  wire logic                   cs_n_i,
    input  wire logic [3:0]             dq_i,
    output logic      [3:0]             dq_o,
    output logic      [3:0]             dq_oe_o,
    // Nonvolatile image and rescue
    input  wire logic [15:0]            nv_prot_i,
    input  wire logic [63:0]            nv_pw_i,
    input  wire logic                   rescue_i,
    // Program/erase query
    input  wire logic [SECT_W-1:0]      chk_sect_i,
    input  wire logic [`FLSP_SUBS_W-1:0] chk_sub_i,
    output logic                        pe_allowed_o,
    // Configuration in force
    output logic                        quad_en_o,
    output logic                        dual_en_o,
    output logic                        dtr_en_o,
    output logic                        hold_rst_en_o,
    output logic      [2:0]             drv_strength_o,
    // Protection state
    output logic      [15:0]            prot_o,
    output logic                        pw_mode_o,
    output logic                        freeze_o
);

    localparam int N_SECT = 1 << SECT_W;
    localparam int N_UNIT = N_SECT - 2 + 2 * SUBS;
    localparam int UNIT_W = $clog2(N_UNIT);

    // End sectors get one unit per subsector, the rest one per sector
    function automatic logic [UNIT_W-1:0] unit_of(input logic [SECT_W-1:0] s,
                                                  input logic [`FLSP_SUBS_W-1:0] u);
        logic [UNIT_W-1:0] r;
        if (s == '0)
            r = UNIT_W'(u);
        else if (s == SECT_W'(N_SECT - 1))
            r = UNIT_W'(SUBS) + UNIT_W'(u);
        else
            r = UNIT_W'(2 * SUBS - 1) + UNIT_W'(s);
        return r;
    endfunction : unit_of

    logic                rst_q1;
    logic                rst_n;
    logic                tg_s1;
    logic                tg_s2;
    logic                tg_s3;
    logic                req_tgl;
    logic [7:0]          req_op;
    logic [63:0]         req_data;
    logic                cmd_vld;
    logic [7:0]          cmd_op;
    logic [63:0]         cmd_data;
    logic [7:0]          protocol_configuration;
    logic [7:0]          active_cfg;
    logic [15:0]         protection_mode_select;
    logic [7:0]          lock_bit_freeze;
    logic                frz;
    logic [63:0]         pw;
    logic                loaded;
    logic [N_SECT-1:0]   nvl;
    logic [N_UNIT-1:0]   vlk;
    logic [7:0]          next_cfg;
    logic [15:0]         next_prot;
    logic                pw_ok;
    logic                unlock_hit;
    logic [SECT_W-1:0]   cmd_sect;
    logic [SECT_W-1:0]   nvl_sect;
    logic [UNIT_W-1:0]   chk_unit;

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // Toggle crossing: op and data stay held by the link until the next one
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tg_s1 <= 1'b0;
            tg_s2 <= 1'b0;
            tg_s3 <= 1'b0;
        end
        else
        begin
            tg_s1 <= req_tgl;
            tg_s2 <= tg_s1;
            tg_s3 <= tg_s2;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_vld  <= 1'b0;
            cmd_op   <= 8'h00;
            cmd_data <= 64'h0;
        end
        else
        begin
            cmd_vld <= tg_s2 ^ tg_s3;
            if (tg_s2 ^ tg_s3)
            begin
                cmd_op   <= req_op;
                cmd_data <= req_data;
            end
        end
    end

    assign cmd_sect = cmd_data[SECT_W+7:8];
    // Lock-bit program carries only the two sector bytes, so its index sits lowest
    assign nvl_sect = cmd_data[SECT_W-1:0];
    assign chk_unit = unit_of(chk_sect_i, chk_sub_i);

    always_comb
    begin
        next_cfg = cmd_data[7:0];
        next_cfg[`FLSP_CFG_RSV] = 1'b1;
        if (cmd_data[2:0] == 3'h0)
            next_cfg[2:0] = protocol_configuration[2:0];
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            protocol_configuration <= `FLSP_CFG_RST;
            active_cfg             <= `FLSP_CFG_RST;
        end
        else if (rescue_i)
        begin
            protocol_configuration <= `FLSP_CFG_RST;
            active_cfg             <= `FLSP_CFG_RST;
        end
        else if (cmd_vld && cmd_op == `FLSP_OP_WR_CFG)
        begin
            protocol_configuration <= next_cfg;
            active_cfg             <= next_cfg;
        end
        else if (cmd_vld && cmd_op == `FLSP_OP_RD_CFG)
            active_cfg <= protocol_configuration;
    end

    assign quad_en_o      = !active_cfg[`FLSP_CFG_QUAD];
    assign dual_en_o      = !active_cfg[`FLSP_CFG_DUAL] && !quad_en_o;
    assign dtr_en_o       = !active_cfg[`FLSP_CFG_DTR];
    assign hold_rst_en_o  = active_cfg[`FLSP_CFG_HOLD] && !quad_en_o;
    assign drv_strength_o = active_cfg[2:0];

    // Only a single mode bit may be cleared, and only while the other is one
    always_comb
    begin
        next_prot = protection_mode_select;
        if (!cmd_data[`FLSP_PROT_PW] && cmd_data[`FLSP_PROT_SP]
            && protection_mode_select[`FLSP_PROT_SP])
            next_prot[`FLSP_PROT_PW] = 1'b0;
        if (!cmd_data[`FLSP_PROT_SP] && cmd_data[`FLSP_PROT_PW]
            && protection_mode_select[`FLSP_PROT_PW])
            next_prot[`FLSP_PROT_SP] = 1'b0;
    end

    // The nonvolatile image is taken in the first cycle after reset release
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loaded                 <= 1'b0;
            protection_mode_select <= `FLSP_PROT_RST;
        end
        else if (!loaded)
        begin
            loaded                 <= 1'b1;
            protection_mode_select <= nv_prot_i | `FLSP_PROT_RSV;
        end
        else if (cmd_vld && cmd_op == `FLSP_OP_WR_PROT)
            protection_mode_select <= next_prot;
    end

    assign pw_mode_o = !protection_mode_select[`FLSP_PROT_PW];
    assign prot_o    = protection_mode_select;

    // No read path for the password exists at all
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            pw <= 64'h0;
        else if (!loaded)
            pw <= nv_pw_i;
        else if (cmd_vld && cmd_op == `FLSP_OP_WR_PW && !pw_mode_o)
            pw <= cmd_data;
    end

    assign pw_ok      = !pw_mode_o || (cmd_data == pw);
    assign unlock_hit = cmd_vld && (cmd_op == `FLSP_OP_UNLOCK) && pw_ok;

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            frz <= `FLSP_FRZ_RST;
        else if (!loaded)
            frz <= nv_prot_i[`FLSP_PROT_PW];
        else if (unlock_hit)
            frz <= 1'b1;
        else if (cmd_vld && cmd_op == `FLSP_OP_WR_FRZ)
            frz <= 1'b0;
    end

    assign lock_bit_freeze = {7'h00, frz};
    assign freeze_o        = frz;

    // Nonvolatile lock bits change only while the freeze bit is one
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            nvl <= '1;
        else if (cmd_vld && frz && cmd_op == `FLSP_OP_WR_NVL)
            nvl[nvl_sect] <= 1'b0;
        else if (cmd_vld && frz && cmd_op == `FLSP_OP_ERASE_NVL)
            nvl <= '1;
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            vlk <= '0;
        else if (cmd_vld && cmd_op == `FLSP_OP_WR_VLK)
            vlk[unit_of(cmd_sect, cmd_data[7:4])] <= cmd_data[0];
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            pe_allowed_o <= 1'b0;
        else
            pe_allowed_o <= nvl[chk_sect_i] && !vlk[chk_unit];
    end

    flsp_link u_link (
        .sck_i      (sck_i),
        .cs_n_i     (cs_n_i),
        .rst_n_i    (rst_n),
        .dq_i       (dq_i),
        .dq_o       (dq_o),
        .dq_oe_o    (dq_oe_o),
        .cfg_i      (active_cfg),
        .rdval_i    ({protocol_configuration, protection_mode_select, lock_bit_freeze}),
        .req_tgl_o  (req_tgl),
        .req_op_o   (req_op),
        .req_data_o (req_data)
    );

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_cmd(logic [7:0] code);
        cmd_vld && cmd_op == code;
    endsequence

    sequence s_unlock_ok;
        unlock_hit;
    endsequence

    a_cfg_download:
        assert property (s_cmd(`FLSP_OP_RD_CFG) |=> active_cfg == $past(protocol_configuration))
        else $error("active config not refreshed after read");

    a_quad_wins:
        assert property (!active_cfg[`FLSP_CFG_QUAD] |-> quad_en_o && !dual_en_o)
        else $error("dual selected while quad bit low");

    a_proto_next:
        assert property (s_cmd(`FLSP_OP_WR_CFG) |=>
                         quad_en_o == !$past(cmd_data[7]) && dtr_en_o == !$past(cmd_data[5]))
        else $error("protocol not applied after config write");

    a_cfg_reserved:
        assert property (protocol_configuration[`FLSP_CFG_RSV]
                         && protocol_configuration[2:0] != 3'h0)
        else $error("reserved config value stored");

    a_rescue_dflt:
        assert property (rescue_i |=> active_cfg == `FLSP_CFG_RST && !quad_en_o && !dual_en_o)
        else $error("rescue did not restore default protocol");

    a_prot_rsv:
        assert property ($past(loaded) |->
                         (protection_mode_select & `FLSP_PROT_RSV) == `FLSP_PROT_RSV)
        else $error("protection reserved bits not one");

    a_otp_excl:
        assert property ($past(loaded) && $fell(protection_mode_select[`FLSP_PROT_PW])
                         |-> protection_mode_select[`FLSP_PROT_SP])
        else $error("password mode taken after sector mode");

    a_otp_sticky:
        assert property ($past(loaded) && pw_mode_o |=> pw_mode_o)
        else $error("password mode bit returned to one");

    a_pw_frozen:
        assert property (s_cmd(`FLSP_OP_WR_PW) ##0 pw_mode_o |=> pw == $past(pw))
        else $error("password changed in password mode");

    a_frz_unlock:
        assert property ($past(loaded) && $rose(frz) |-> $past(unlock_hit))
        else $error("freeze bit set without valid unlock");

    a_frz_set:
        assert property (s_unlock_ok |=> frz [*2] ##1 1'b1)
        else $error("unlock did not set freeze bit");

    a_frz_write:
        assert property (s_cmd(`FLSP_OP_WR_FRZ) ##0 !unlock_hit |=> !frz)
        else $error("freeze write did not clear bit");

    a_frz_boot:
        assert property ($rose(loaded) |=> frz == !pw_mode_o && vlk == '0)
        else $error("freeze or volatile locks wrong after reset");

    a_nvl_guard:
        assert property (cmd_vld && !frz |=> nvl == $past(nvl))
        else $error("lock bits changed while frozen");

    a_pe_block:
        assert property ($past(vlk[chk_unit]) |-> !pe_allowed_o)
        else $error("program allowed in write-locked unit");

endmodule : flsp_core

//--- verif/flsp_host.sv
// Serial host model: drives link clock, frame select and data lines.
// Assumes the bench resolves the data lines from the device's output enables.
`timescale 1ns/1ps

module flsp_host
(
    // Link outputs
    output logic            sck_o,
    output logic            cs_n_o,
    output logic [3:0]      dq_o,
    // Resolved data lines
    input  wire logic [3:0] dq_i
);
    initial
    begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        dq_o   = 4'hF;
    end

    // One command a frame; w bits an edge, nb payload bytes, nr bits read on dq[1]
    task automatic xfer(input int w, input logic [7:0] op, input int nb,
                        input logic [63:0] pl, input int nr, output logic [15:0] rd);
        logic [71:0] sr;
        // Payload is left-aligned under the opcode; the opcode shifts out first, from bit 71
        sr = {op, pl << (8 * (8 - nb))};
        rd = 16'h0;
        cs_n_o = 1'b0;
        for (int i = 0; i < 8 * (nb + 1); i += w)
        begin
            // Unused lines stay high so the hold input never stalls a frame
            dq_o = 4'hF;
            for (int k = 0; k < w; k++)
                dq_o[w-1-k] = sr[71-i-k];
            #62.5 sck_o = 1'b1;
            #62.5 sck_o = 1'b0;
        end
        for (int j = 0; j < nr; j++)
        begin
            rd = {rd[14:0], dq_i[1]};
            dq_o[0] = ~dq_o[0];
            #62.5 sck_o = 1'b1;
            #62.5 sck_o = 1'b0;
        end
        #62.5 cs_n_o = 1'b1;
        // Released lines do not keep their last value
        dq_o = ~dq_o;
        #600;
    endtask : xfer
endmodule : flsp_host

//--- verif/testbench.sv
// Self-checking bench of the flash protection core with a serial host model.
// Assumes a 25 MHz core clock and a 125 ns link clock made by the host.
`timescale 1ns/1ps
`include "flsp_consts.svh"

module testbench;
    typedef struct { int w; logic [7:0] op; int nb; logic [63:0] pl; logic [25:0] e; } flsp_row_s;
    localparam logic [63:0] PW_A = 64'h0123_4567_89AB_CDEF;
    localparam logic [63:0] PW_B = 64'hFEDC_BA98_7654_3210;

    logic        clk, rstn, rescue, sck, cs_n, pe, quad, dual, dtr, hold, pwm, frz;
    logic [3:0]  h_dq, d_dq, d_oe, dq_w, sect, sub;
    logic [2:0]  drv;
    logic [15:0] nv_prot, prot, rd;
    logic [63:0] nv_pw;
    int          err_total, checks, cyc;

    flsp_row_s rows [16] = '{
        '{1, `FLSP_OP_WR_CFG, 1, 64'hBC, {7'h2C, 2'h2, 16'hFFFF}},
        '{2, `FLSP_OP_WR_CFG, 1, 64'hFF, {7'h0F, 2'h2, 16'hFFFF}},
        '{1, `FLSP_OP_WR_CFG, 1, 64'h3A, {7'h42, 2'h2, 16'hFFFF}},
        '{4, `FLSP_OP_WR_CFG, 1, 64'hD8, {7'h1A, 2'h2, 16'hFFFF}},
        '{1, `FLSP_OP_WR_CFG, 1, 64'hFF, {7'h0F, 2'h2, 16'hFFFF}},
        '{1, `FLSP_OP_WR_FRZ, 0, 64'h0, {7'h0F, 2'h0, 16'hFFFF}},
        '{1, `FLSP_OP_UNLOCK, 8, PW_B, {7'h0F, 2'h2, 16'hFFFF}},
        '{1, `FLSP_OP_WR_PROT, 2, 64'hFFF9, {7'h0F, 2'h2, 16'hFFFF}},
        '{1, `FLSP_OP_WR_PROT, 2, 64'h0006, {7'h0F, 2'h2, 16'hFFFF}},
        '{1, `FLSP_OP_WR_PW, 8, PW_A, {7'h0F, 2'h2, 16'hFFFF}},
        '{1, `FLSP_OP_WR_PROT, 2, 64'hFFFB, {7'h0F, 2'h3, 16'hFFFB}},
        '{1, `FLSP_OP_WR_PROT, 2, 64'hFFFD, {7'h0F, 2'h3, 16'hFFFB}},
        '{1, `FLSP_OP_WR_PW, 8, PW_B, {7'h0F, 2'h3, 16'hFFFB}},
        '{1, `FLSP_OP_WR_FRZ, 0, 64'h0, {7'h0F, 2'h1, 16'hFFFB}},
        '{1, `FLSP_OP_UNLOCK, 8, PW_B, {7'h0F, 2'h1, 16'hFFFB}},
        '{1, `FLSP_OP_UNLOCK, 8, PW_A, {7'h0F, 2'h3, 16'hFFFB}}};

    assign dq_w = (d_oe & d_dq) | (~d_oe & h_dq);

    flsp_host flsp_host_i (.sck_o(sck), .cs_n_o(cs_n), .dq_o(h_dq), .dq_i(dq_w));

    flsp_core #(.SECT_W(4), .SUBS(16)) flsp_core_i (
        .core_clk_i(clk), .rstn_i(rstn), .sck_i(sck), .cs_n_i(cs_n), .dq_i(dq_w),
        .dq_o(d_dq), .dq_oe_o(d_oe), .nv_prot_i(nv_prot), .nv_pw_i(nv_pw),
        .rescue_i(rescue), .chk_sect_i(sect), .chk_sub_i(sub), .pe_allowed_o(pe),
        .quad_en_o(quad), .dual_en_o(dual), .dtr_en_o(dtr), .hold_rst_en_o(hold),
        .drv_strength_o(drv), .prot_o(prot), .pw_mode_o(pwm), .freeze_o(frz));

    task automatic complete_run;
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [25:0] e, input logic [25:0] g);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic pe_chk(input logic [3:0] s, input logic [3:0] u, input logic e);
        @(negedge clk);
        sect = s;
        sub  = u;
        repeat (2) @(negedge clk);
        chk("pe_allowed", {25'h0, e}, {25'h0, pe});
    endtask : pe_chk

    task automatic do_reset(input logic [15:0] p);
        @(negedge clk);
        rstn    = 1'b0;
        nv_prot = p;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (6) @(negedge clk);
    endtask : do_reset

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            complete_run();
        end
    end

    initial
    begin
        {rstn, rescue, sect, sub, nv_pw, err_total, checks, cyc} = '0;
        do_reset(16'hFFFF);
        chk("reset", {7'h0F, 2'h2, 16'hFFFF}, {quad, dual, dtr, hold, drv, frz, pwm, prot});
        pe_chk(4'h0, 4'h0, 1'b1);
        foreach (rows[i])
        begin
            flsp_host_i.xfer(rows[i].w, rows[i].op, rows[i].nb, rows[i].pl, 0, rd);
            chk($sformatf("row %0d", i), rows[i].e, {quad, dual, dtr, hold, drv, frz, pwm, prot});
        end
        flsp_host_i.xfer(1, `FLSP_OP_WR_CFG, 1, 64'hBC, 0, rd);
        @(negedge clk);
        rescue = 1'b1;
        @(negedge clk);
        rescue = 1'b0;
        repeat (2) @(negedge clk);
        chk("rescue", {7'h0F, 2'h3, 16'hFFFB}, {quad, dual, dtr, hold, drv, frz, pwm, prot});
        flsp_host_i.xfer(1, `FLSP_OP_RD_CFG, 0, 64'h0, 16, rd);
        chk("rd_cfg", {10'h0, 16'hFF00}, {10'h0, rd});
        flsp_host_i.xfer(1, `FLSP_OP_RD_FRZ, 0, 64'h0, 16, rd);
        chk("rd_frz", {10'h0, 16'h0100}, {10'h0, rd});
        flsp_host_i.xfer(1, `FLSP_OP_RD_PROT, 0, 64'h0, 16, rd);
        chk("rd_prot", {10'h0, 16'hFFFB}, {10'h0, rd});
        flsp_host_i.xfer(1, `FLSP_OP_WR_VLK, 3, 64'h31, 0, rd);
        pe_chk(4'h0, 4'h3, 1'b0);
        pe_chk(4'h0, 4'h4, 1'b1);
        flsp_host_i.xfer(1, `FLSP_OP_WR_NVL, 2, 64'h2, 0, rd);
        pe_chk(4'h2, 4'h0, 1'b0);
        flsp_host_i.xfer(1, `FLSP_OP_WR_FRZ, 0, 64'h0, 0, rd);
        flsp_host_i.xfer(1, `FLSP_OP_ERASE_NVL, 0, 64'h0, 0, rd);
        pe_chk(4'h2, 4'h0, 1'b0);
        flsp_host_i.xfer(1, `FLSP_OP_UNLOCK, 8, PW_A, 0, rd);
        flsp_host_i.xfer(1, `FLSP_OP_ERASE_NVL, 0, 64'h0, 0, rd);
        pe_chk(4'h2, 4'h0, 1'b1);
        nv_pw = PW_A;
        do_reset(16'hFFFB);
        chk("pw_reset", {7'h0F, 2'h1, 16'hFFFB}, {quad, dual, dtr, hold, drv, frz, pwm, prot});
        pe_chk(4'h0, 4'h3, 1'b1);
        flsp_host_i.xfer(1, `FLSP_OP_WR_NVL, 2, 64'h2, 0, rd);
        pe_chk(4'h2, 4'h0, 1'b1);
        complete_run();
    end
endmodule : testbench
